// ---- pmh_link_partner.sv ----
// Link partner model that takes outgoing message TLPs from the device.
`timescale 1ns/100ps

module pmh_link_partner (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Message handshake from the device.
  input wire logic tx_msg_valid,
  input wire logic [7:0] tx_msg_code,
  output logic tx_msg_ready,
  // Pace control and record of taken messages.
  input wire logic slow,
  output logic [7:0] last_code,
  output logic [7:0] msg_count
);
  logic tick_q;
  // Ready every cycle when prompt, every other cycle when slow.
  assign tx_msg_ready = !slow || tick_q;
  // Take turn-off, acknowledge, interrupt and error messages on the handshake edge.
  always_ff @(posedge clk) begin
    if (rst) begin
      tick_q <= 1'b0;
      last_code <= 8'h00;
      msg_count <= 8'h00;
    end else begin
      tick_q <= !tick_q;
      if (tx_msg_valid && tx_msg_ready) begin
        last_code <= tx_msg_code;
        msg_count <= msg_count + 8'h01;
      end
    end
  end
endmodule

// ---- pmh_msg_handler.sv ----
// Message handling: interrupts, turn-off handshake and error reporting.
`timescale 1ns/100ps

module pmh_msg_handler (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Role: high for Root Port, low for Endpoint.
  input wire logic root_port_mode,
  // Received message strobe.
  input wire logic rx_msg_valid,
  input wire logic [7:0] rx_msg_code,
  // Transmitted message handshake.
  output logic tx_msg_valid,
  output logic [7:0] tx_msg_code,
  input wire logic tx_msg_ready,
  // Endpoint legacy interrupt level and Root Port interrupt status.
  input wire logic app_inta_level,
  output logic [pmh_pkg::INT_LINES-1:0] int_status,
  // Turn-off handshake.
  input wire logic turn_off_request,
  output logic turn_off_received,
  output logic turn_off_ack_seen,
  // Error detection and reporting.
  input wire logic [pmh_pkg::ERR_KINDS-1:0] local_err_detect,
  input wire logic error_clear,
  output logic error_logged,
  output logic [pmh_pkg::ERR_KINDS-1:0] error_kind,
  // Error MSI request.
  input wire logic aer_enable,
  input wire logic [pmh_pkg::MSI_W-1:0] error_msi_vector,
  output logic msi_valid,
  output logic [pmh_pkg::MSI_W-1:0] msi_vector,
  input wire logic msi_ready
);
  import pmh_pkg::*;

  // ============================================================
  // Message decode
  // ============================================================
  // Receive side decode of the incoming message code.
  wire rx_int_on = rx_msg_valid && rx_msg_code >= MSG_ASSERT_INTA
                   && rx_msg_code <= MSG_ASSERT_INTD;
  wire rx_int_off = rx_msg_valid && rx_msg_code >= MSG_DEASSERT_INTA
                    && rx_msg_code <= MSG_DEASSERT_INTD;
  wire rx_turn_off = rx_msg_valid && rx_msg_code == MSG_TURN_OFF;
  wire rx_to_ack = rx_msg_valid && rx_msg_code == MSG_TURN_OFF_ACK;
  wire [ERR_KINDS-1:0] rx_err = {rx_msg_valid && rx_msg_code == MSG_ERR_FATAL,
                                 rx_msg_valid && rx_msg_code == MSG_ERR_NONFATAL,
                                 rx_msg_valid && rx_msg_code == MSG_ERR_COR};
  wire [1:0] rx_line = rx_msg_code[1:0];

  // ============================================================
  // Root Port interrupt status
  // ============================================================
  logic [INT_LINES-1:0] int_q, int_d;

  // One status bit per line; assert sets and deassert clears it.
  for (genvar g = 0; g < INT_LINES; g++) begin : g_line
    wire hit = root_port_mode && rx_line == 2'(g);
    assign int_d[g] = !root_port_mode ? 1'b0 :
                      (hit && rx_int_on) ? 1'b1 :
                      (hit && rx_int_off) ? 1'b0 : int_q[g];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      int_q <= '0;
    end else begin
      int_q <= int_d;
    end
  end
  assign int_status = int_q;

  // ============================================================
  // Turn-off handshake
  // ============================================================
  pmh_to_state_e to_q, to_d;
  logic ack_seen_q;
  wire rp_to_start = root_port_mode && to_q == TO_IDLE && turn_off_request;
  wire ep_to_ack = !root_port_mode && to_q == TO_EP_RCVD && turn_off_request;

  // Root Port waits for the acknowledge; Endpoint waits for the application.
  always_comb begin
    to_d = to_q;
    unique case (to_q)
      TO_IDLE: begin
        if (rp_to_start) begin
          to_d = TO_RP_SENT;
        end else if (!root_port_mode && rx_turn_off) begin
          to_d = TO_EP_RCVD;
        end
      end
      TO_RP_SENT: begin
        if (rx_to_ack || !root_port_mode) begin
          to_d = TO_IDLE;
        end
      end
      TO_EP_RCVD: begin
        if (ep_to_ack || root_port_mode) begin
          to_d = TO_IDLE;
        end
      end
      default: to_d = TO_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      to_q <= TO_IDLE;
      ack_seen_q <= 1'b0;
    end else begin
      to_q <= to_d;
      ack_seen_q <= to_q == TO_RP_SENT && rx_to_ack;
    end
  end
  assign turn_off_received = to_q == TO_EP_RCVD;
  assign turn_off_ack_seen = ack_seen_q;

  // ============================================================
  // Transmit requests
  // ============================================================
  logic inta_prev_q;
  logic [REQ_N-1:0] pend_q, pend_d, set_req, grant;
  wire ep_mode = !root_port_mode;

  // Endpoint drives only line A, from the edges of the application level.
  assign set_req[REQ_INTA_ON] = ep_mode && app_inta_level && !inta_prev_q;
  assign set_req[REQ_INTA_OFF] = ep_mode && !app_inta_level && inta_prev_q;
  assign set_req[REQ_TURN_OFF] = rp_to_start;
  assign set_req[REQ_TO_ACK] = ep_to_ack;
  assign set_req[REQ_N-1:REQ_ERR0] = ep_mode ? local_err_detect : '0;
  // A new request wins over the grant that retires the same slot.
  assign pend_d = set_req | (pend_q & ~grant);

  always_ff @(posedge clk) begin
    if (rst) begin
      pend_q <= '0;
      inta_prev_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
      inta_prev_q <= app_inta_level;
    end
  end

  pmh_tx_sched u_sched (
    .clk(clk),
    .rst(rst),
    .req(pend_q),
    .grant(grant),
    .tx_valid(tx_msg_valid),
    .tx_code(tx_msg_code),
    .tx_ready(tx_msg_ready)
  );

  // ============================================================
  // Root Port error collection
  // ============================================================
  logic err_q, msi_q;
  logic [ERR_KINDS-1:0] kind_q;
  logic [MSI_W-1:0] vec_q;
  // Received and locally detected errors are logged the same way.
  wire [ERR_KINDS-1:0] err_new = root_port_mode ? (rx_err | local_err_detect) : '0;
  wire err_event = |err_new;
  wire msi_load = err_event && aer_enable && !msi_q;

  // Sticky log; a new error in the clearing cycle keeps the flag set.
  always_ff @(posedge clk) begin
    if (rst) begin
      err_q <= 1'b0;
      kind_q <= '0;
    end else begin
      err_q <= err_event | (err_q & ~error_clear);
      kind_q <= err_new | (kind_q & {ERR_KINDS{~error_clear}});
    end
  end

  // MSI request carries the vector the application gave when the request was raised.
  always_ff @(posedge clk) begin
    if (rst) begin
      msi_q <= 1'b0;
      vec_q <= '0;
    end else begin
      msi_q <= msi_load | (msi_q & ~msi_ready);
      if (msi_load) begin
        vec_q <= error_msi_vector;
      end
    end
  end
  assign error_logged = err_q;
  assign error_kind = kind_q;
  assign msi_valid = msi_q;
  assign msi_vector = vec_q;

  // ============================================================
  // Checks
  // ============================================================
  property p_ep_inta_only;
    @(posedge clk) disable iff (rst) tx_msg_valid |->
      !(tx_msg_code > MSG_ASSERT_INTA && tx_msg_code <= MSG_ASSERT_INTD) &&
      !(tx_msg_code > MSG_DEASSERT_INTA && tx_msg_code <= MSG_DEASSERT_INTD);
  endproperty
  a_ep_inta_only: assert property (p_ep_inta_only) else $error("Non-A line sent.");

  property p_int_set;
    @(posedge clk) disable iff (rst) root_port_mode && rx_int_on ##1 root_port_mode
      |-> int_status[$past(rx_line)];
  endproperty
  a_int_set: assert property (p_int_set) else $error("Status bit not set.");

  property p_int_clr;
    @(posedge clk) disable iff (rst) rx_int_off |=> !int_status[$past(rx_line)];
  endproperty
  a_int_clr: assert property (p_int_clr) else $error("Status bit not cleared.");

  property p_int_ep_zero;
    @(posedge clk) disable iff (rst) !root_port_mode |=> int_status == '0;
  endproperty
  a_int_ep_zero: assert property (p_int_ep_zero) else $error("Endpoint status.");

  sequence s_rp_req;
    root_port_mode && to_q == TO_IDLE && turn_off_request;
  endsequence
  property p_rp_turn_off;
    @(posedge clk) disable iff (rst) s_rp_req |=> pend_q[REQ_TURN_OFF] && to_q == TO_RP_SENT;
  endproperty
  a_rp_turn_off: assert property (p_rp_turn_off) else $error("Turn-off not queued.");

  sequence s_ep_got;
    !root_port_mode && rx_turn_off && to_q == TO_IDLE ##1 !root_port_mode && turn_off_request;
  endsequence
  property p_ep_ack;
    @(posedge clk) disable iff (rst) s_ep_got |=> pend_q[REQ_TO_ACK] && to_q == TO_IDLE;
  endproperty
  a_ep_ack: assert property (p_ep_ack) else $error("Acknowledge not queued.");

  property p_err_log;
    @(posedge clk) disable iff (rst) root_port_mode && (|rx_err) |=> error_logged;
  endproperty
  a_err_log: assert property (p_err_log) else $error("Received error not logged.");

  property p_err_hold;
    @(posedge clk) disable iff (rst) error_logged && !error_clear |=> error_logged;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("Error flag lost.");

  property p_msi_vec;
    @(posedge clk) disable iff (rst) err_event && aer_enable && !msi_valid
      |=> msi_valid && msi_vector == $past(error_msi_vector);
  endproperty
  a_msi_vec: assert property (p_msi_vec) else $error("Wrong MSI vector.");
endmodule

// ---- pmh_msg_handler_bench.sv ----
// Self-checking bench for the message handler.
`timescale 1ns/100ps

module pmh_msg_handler_bench;
  import pmh_pkg::*;
  logic clk = 1'b0, rst = 1'b1, rpm = 1'b1, rxv = 1'b0, rdy, inta = 1'b0, tor = 1'b0;
  logic eclr = 1'b0, aer = 1'b1, msir = 1'b0, slow = 1'b0, txv, tor_rx, ack_seen, elog, msiv;
  logic [7:0] rxc = 8'h00, txc, last, cnt;
  logic [3:0] ints;
  logic [2:0] lerr = 3'h0, ekind;
  logic [4:0] vec = 5'h15, msivec;
  int num_errors = 0, num_checks = 0;
  // Ordinary rows: received interrupt code and the status it should leave.
  logic [11:0] rows [8] = '{12'h201, 12'h239, 12'h21B, 12'h22F, 12'h24E, 12'h276, 12'h254, 12'h260};

  pmh_msg_handler u_pmh_msg_handler (.clk(clk), .rst(rst), .root_port_mode(rpm),
    .rx_msg_valid(rxv), .rx_msg_code(rxc), .tx_msg_valid(txv), .tx_msg_code(txc),
    .tx_msg_ready(rdy), .app_inta_level(inta), .int_status(ints), .turn_off_request(tor),
    .turn_off_received(tor_rx), .turn_off_ack_seen(ack_seen), .local_err_detect(lerr),
    .error_clear(eclr), .error_logged(elog), .error_kind(ekind), .aer_enable(aer),
    .error_msi_vector(vec), .msi_valid(msiv), .msi_vector(msivec), .msi_ready(msir));
  pmh_link_partner u_pmh_link_partner (.clk(clk), .rst(rst), .tx_msg_valid(txv),
    .tx_msg_code(txc), .tx_msg_ready(rdy), .slow(slow), .last_code(last), .msg_count(cnt));

  // ============================================================
  // Clock and shared tasks
  // Free-running clock of 25 ns.
  always #12.5 clk = ~clk;

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic give_verdict();
    if (num_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic do_reset();
    rst = 1'b1;
    repeat (4) @(negedge clk);
    rst = 1'b0;
  endtask

  // One-cycle receive strobe; results stand at the following falling edge.
  task automatic rx(input logic [7:0] code);
    @(negedge clk);
    rxv = 1'b1;
    rxc = code;
    @(negedge clk);
    rxv = 1'b0;
  endtask

  // Waits a bounded time for the partner to take a message, then checks its code.
  task automatic wait_tx(input logic [7:0] exp);
    logic [7:0] old;
    old = cnt;
    for (int i = 0; i < 20 && cnt === old; i++) @(negedge clk);
    chk("tx_code", exp, last);
  endtask

  // ============================================================
  // Watchdog
  initial begin
    #(3000 * 25);
    num_errors++;
    give_verdict();
  end

  // ============================================================
  // Main sequence
  initial begin
    do_reset();
    chk("rst_int", 8'h00, {4'h0, ints});
    chk("rst_flags", 8'h00, {4'h0, txv, elog, msiv, tor_rx});
    foreach (rows[i]) begin
      rx(rows[i][11:4]);
      chk("int_status", {4'h0, rows[i][3:0]}, {4'h0, ints});
    end
    rx(MSG_TURN_OFF);
    chk("rp_no_rcvd", 8'h00, {7'h0, tor_rx});
    // Root Port turn-off and its acknowledge.
    tor = 1'b1;
    @(negedge clk);
    tor = 1'b0;
    wait_tx(MSG_TURN_OFF);
    rx(MSG_TURN_OFF_ACK);
    chk("ack_seen", 8'h01, {7'h0, ack_seen});
    // Error logging with a held MSI request; the application picks the vector.
    rx(MSG_ERR_NONFATAL);
    chk("elog", 8'h01, {7'h0, elog});
    chk("ekind", 8'h02, {5'h0, ekind});
    chk("msi", 8'h35, {2'h0, msiv, msivec});
    vec = 5'h0A;
    lerr = 3'h4;
    @(negedge clk);
    lerr = 3'h0;
    chk("ekind_local", 8'h06, {5'h0, ekind});
    chk("msi_held", 8'h35, {2'h0, msiv, msivec});
    msir = 1'b1;
    @(negedge clk);
    msir = 1'b0;
    chk("msi_done", 8'h00, {7'h0, msiv});
    eclr = 1'b1;
    @(negedge clk);
    eclr = 1'b0;
    chk("elog_clr", 8'h00, {4'h0, elog, ekind});
    rx(MSG_ERR_COR);
    rx(MSG_ERR_FATAL);
    chk("ekind_rx", 8'h0D, {4'h0, elog, ekind});
    chk("msi_new_vec", 8'h2A, {2'h0, msiv, msivec});
    // Endpoint role with a slow partner.
    rpm = 1'b0;
    slow = 1'b1;
    do_reset();
    rx(MSG_ASSERT_INTD);
    rx(MSG_ERR_FATAL);
    chk("ep_refused", 8'h00, {3'h0, elog, ints});
    inta = 1'b1;
    wait_tx(MSG_ASSERT_INTA);
    inta = 1'b0;
    wait_tx(MSG_DEASSERT_INTA);
    rx(MSG_TURN_OFF);
    chk("ep_rcvd", 8'h01, {7'h0, tor_rx});
    tor = 1'b1;
    @(negedge clk);
    tor = 1'b0;
    wait_tx(MSG_TURN_OFF_ACK);
    chk("ep_rcvd_off", 8'h00, {7'h0, tor_rx});
    // Endpoint local errors leave as messages, correctable before fatal, and log nothing.
    lerr = 3'h5;
    @(negedge clk);
    lerr = 3'h0;
    wait_tx(MSG_ERR_COR);
    wait_tx(MSG_ERR_FATAL);
    chk("ep_no_log", 8'h00, {7'h0, elog});
    give_verdict();
  end
endmodule

// ---- pmh_tx_sched.sv ----
// Shared constants and the transmit message scheduler.
// ============================================================
`timescale 1ns/100ps

package pmh_pkg;
  // Message codes carried on the message ports.
  localparam logic [7:0] MSG_ASSERT_INTA = 8'h20;
  localparam logic [7:0] MSG_ASSERT_INTD = 8'h23;
  localparam logic [7:0] MSG_DEASSERT_INTA = 8'h24;
  localparam logic [7:0] MSG_DEASSERT_INTD = 8'h27;
  localparam logic [7:0] MSG_TURN_OFF = 8'h19;
  localparam logic [7:0] MSG_TURN_OFF_ACK = 8'h1B;
  localparam logic [7:0] MSG_ERR_COR = 8'h30;
  localparam logic [7:0] MSG_ERR_NONFATAL = 8'h31;
  localparam logic [7:0] MSG_ERR_FATAL = 8'h33;
  // Transmit request slots, lowest index wins.
  localparam int REQ_N = 7;
  localparam int REQ_INTA_ON = 0;
  localparam int REQ_INTA_OFF = 1;
  localparam int REQ_TURN_OFF = 2;
  localparam int REQ_TO_ACK = 3;
  localparam int REQ_ERR0 = 4;
  localparam logic [7:0] REQ_CODE [REQ_N] = '{MSG_ASSERT_INTA, MSG_DEASSERT_INTA,
    MSG_TURN_OFF, MSG_TURN_OFF_ACK, MSG_ERR_COR, MSG_ERR_NONFATAL, MSG_ERR_FATAL};
  // Widths and reset values.
  localparam int INT_LINES = 4;
  localparam int ERR_KINDS = 3;
  localparam int MSI_W = 5;
  localparam logic [7:0] CODE_RST = 8'h00;
  // Turn-off handshake states.
  typedef enum logic [2:0] {
    TO_IDLE = 3'b001,
    TO_RP_SENT = 3'b010,
    TO_EP_RCVD = 3'b100
  } pmh_to_state_e;
endpackage

module pmh_tx_sched (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Pending requests and the one-cycle grant that retires one.
  input wire logic [pmh_pkg::REQ_N-1:0] req,
  output logic [pmh_pkg::REQ_N-1:0] grant,
  // Outgoing message handshake.
  output logic tx_valid,
  output logic [7:0] tx_code,
  input wire logic tx_ready
);
  import pmh_pkg::*;

  logic [REQ_N-1:0] sel_q, sel_d, pick;
  logic [7:0] code_q, pick_code;
  logic valid_q;
  wire done = valid_q & tx_ready;
  wire load = ~valid_q & (|req);

  // Fixed-priority pick of the lowest pending slot.
  always_comb begin
    pick = '0;
    pick_code = CODE_RST;
    for (int i = REQ_N - 1; i >= 0; i--) begin
      if (req[i]) begin
        pick = '0;
        pick[i] = 1'b1;
        pick_code = REQ_CODE[i];
      end
    end
  end

  assign sel_d = load ? pick : sel_q;
  assign grant = done ? sel_q : '0;
  assign tx_valid = valid_q;
  assign tx_code = code_q;

  // Message stays on the port until the far side takes it.
  always_ff @(posedge clk) begin
    if (rst) begin
      valid_q <= 1'b0;
      sel_q <= '0;
      code_q <= CODE_RST;
    end else begin
      valid_q <= load | (valid_q & ~tx_ready);
      sel_q <= sel_d;
      if (load) begin
        code_q <= pick_code;
      end
    end
  end

  property p_tx_hold;
    @(posedge clk) disable iff (rst) tx_valid && !tx_ready |=> tx_valid && $stable(tx_code);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("Message dropped before accept.");
endmodule
